// ==== include/djkff_regs.svh ====
// Constants for the dual falling-edge set/reset/toggle storage block.
`ifndef DJKFF_REGS_SVH
`define DJKFF_REGS_SVH

// ----------------------------------------------------------------
// Structure
// ----------------------------------------------------------------
`define DJKFF_NCELLS       2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DJKFF_RST_STATE    1'h0
`define DJKFF_RST_STATE_N  1'h1
`define DJKFF_RST_CLK_PREV 1'h0

`endif

// ==== include/djkff_pkg.sv ====
// Types shared by the dual storage cell block.
`include "djkff_regs.svh"

package djkff_pkg;

	localparam int unsigned DJKFF_CELLS = `DJKFF_NCELLS;

	// ----------------------------------------------------------------
	// State of the top module: true and complement per cell
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DJKFF_CELLS-1:0] state;
		logic [DJKFF_CELLS-1:0] state_n;
	} djkff_state_t;

	// ----------------------------------------------------------------
	// State of one falling-edge detector
	// ----------------------------------------------------------------
	typedef struct packed {
		logic clk_prev;
	} djkff_det_t;

endpackage

// ==== design/djkff_fall_det.sv ====
// Falling-edge detector for one cell clock sampled on the system clock.
`include "djkff_regs.svh"

module djkff_fall_det (
	// System
	input  wire logic sys_clk,
	input  wire logic rst,
	// Cell clock level and its falling edge
	input  wire logic cell_clk,
	output logic      fall
);
	import djkff_pkg::*;

	djkff_det_t st_q;
	djkff_det_t st_d;

	// Reset low so a clock already low at release gives no false edge.
	always_comb begin
		st_d          = st_q;
		st_d.clk_prev = cell_clk;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q.clk_prev <= `DJKFF_RST_CLK_PREV;
		end else begin
			st_q <= st_d;
		end
	end

	assign fall = st_q.clk_prev & ~cell_clk;

endmodule

// ==== design/djkff_top.sv ====
// Two independent falling-edge set/reset/toggle storage cells with async overrides.
`include "djkff_regs.svh"

// Functional notes
// - Two independent cells, true and complement outputs
// - Inputs sampled only on own clock fall
// - Steady clock: set/reset input changes never move outputs
// - Async set or clear overrides everything but rst
// - Both async low: both outputs high
// - Fall with both inputs low holds
// - Fall with both inputs high toggles
module djkff_top (
	// System
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	// Per-cell clocks and sampled control inputs
	input  wire logic [djkff_pkg::DJKFF_CELLS-1:0] cell_clk,
	input  wire logic [djkff_pkg::DJKFF_CELLS-1:0] set_input,
	input  wire logic [djkff_pkg::DJKFF_CELLS-1:0] reset_input,
	// Per-cell asynchronous overrides
	input  wire logic [djkff_pkg::DJKFF_CELLS-1:0] async_set_n,
	input  wire logic [djkff_pkg::DJKFF_CELLS-1:0] async_clear_n,
	// Per-cell outputs
	output logic      [djkff_pkg::DJKFF_CELLS-1:0] state_out,
	output logic      [djkff_pkg::DJKFF_CELLS-1:0] state_out_inv
);
	import djkff_pkg::*;

	localparam int unsigned N = DJKFF_CELLS;

	djkff_state_t   st_q;
	djkff_state_t   st_d;
	logic [N-1:0]   fall;

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	// Each cell has its own detector so the cells never interact.
	for (genvar g = 0; g < N; g++) begin : g_det
		djkff_fall_det u_det (
			.sys_clk  (sys_clk),
			.rst      (rst),
			.cell_clk (cell_clk[g]),
			.fall     (fall[g])
		);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// The overrides take effect at the next system clock edge, not
	// combinationally, so that every output stays a plain flip-flop.
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < N; i++) begin
			if (!async_set_n[i] && !async_clear_n[i]) begin
				st_d.state[i]   = 1'h1;
				st_d.state_n[i] = 1'h1;
			end else if (!async_set_n[i]) begin
				st_d.state[i]   = 1'h1;
				st_d.state_n[i] = 1'h0;
			end else if (!async_clear_n[i]) begin
				st_d.state[i]   = 1'h0;
				st_d.state_n[i] = 1'h1;
			end else if (fall[i]) begin
				case ({set_input[i], reset_input[i]})
					2'h2: st_d.state[i] = 1'h1;
					2'h1: st_d.state[i] = 1'h0;
					2'h3: st_d.state[i] = ~st_q.state[i];
					default: st_d.state[i] = st_q.state[i];
				endcase
				st_d.state_n[i] = ~st_d.state[i];
			end else begin
				// hold without edge
				// Leaving the both-low condition keeps the true output and
				// repairs the complement, since the pair must not stay equal.
				st_d.state[i]   = st_q.state[i];
				st_d.state_n[i] = ~st_q.state[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q.state   <= {N{`DJKFF_RST_STATE}};
			st_q.state_n <= {N{`DJKFF_RST_STATE_N}};
		end else begin
			st_q <= st_d;
		end
	end

	assign state_out     = st_q.state;
	assign state_out_inv = st_q.state_n;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	for (genvar c = 0; c < N; c++) begin : g_chk
		logic quiet;
		assign quiet = async_set_n[c] & async_clear_n[c];

		sequence s_fall_with(logic sv, logic rv);
			quiet && fall[c] && set_input[c] == sv && reset_input[c] == rv;
		endsequence

		sequence s_no_edge;
			quiet && !fall[c];
		endsequence

		sequence s_both_low;
			!async_set_n[c] && !async_clear_n[c];
		endsequence

		a_complement_pair:
		assert property (quiet ##1 quiet |-> state_out[c] != state_out_inv[c])
			else $error("True and complement outputs are equal.");

		a_edge_only:
		assert property ($changed(state_out[c]) |->
			$past(fall[c]) || !$past(async_set_n[c]) || !$past(async_clear_n[c]))
			else $error("True output moved without edge or override.");

		a_steady_hold:
		assert property (s_no_edge ##1 s_no_edge |=> $stable(state_out[c])
			&& $stable(state_out_inv[c]))
			else $error("Outputs moved while clock held steady.");

		a_async_set:
		assert property (!async_set_n[c] && async_clear_n[c]
			|=> state_out[c] && !state_out_inv[c])
			else $error("Async set did not force outputs.");

		a_async_clear:
		assert property (async_set_n[c] && !async_clear_n[c]
			|=> !state_out[c] && state_out_inv[c])
			else $error("Async clear did not force outputs.");

		a_both_low_high:
		assert property (s_both_low |=> state_out[c] && state_out_inv[c])
			else $error("Both overrides low did not drive both high.");

		a_fall_hold:
		assert property (s_fall_with(1'h0, 1'h0) |=> $stable(state_out[c]))
			else $error("Fall with both inputs low changed output.");

		a_fall_toggle:
		assert property (s_fall_with(1'h1, 1'h1)
			|=> state_out[c] == !$past(state_out[c])
			&& state_out_inv[c] == !state_out[c])
			else $error("Fall with both inputs high did not toggle.");

		a_fall_set:
		assert property (s_fall_with(1'h1, 1'h0) |=> state_out[c] && !state_out_inv[c])
			else $error("Fall with set only did not set.");

		a_fall_reset:
		assert property (s_fall_with(1'h0, 1'h1) |=> !state_out[c] && state_out_inv[c])
			else $error("Fall with reset only did not clear.");

		// ----------------------------------------------------------------
		// Override persistence and release
		// ----------------------------------------------------------------
		sequence s_only_set;
			!async_set_n[c] && async_clear_n[c];
		endsequence

		sequence s_only_clear;
			async_set_n[c] && !async_clear_n[c];
		endsequence

		// A release right after both overrides were low leaves the pair equal
		// for one cycle, so the repair step is checked on its own.
		sequence s_released;
			s_both_low ##1 (quiet && !fall[c]);
		endsequence

		a_set_holds:
		assert property (s_only_set ##1 s_only_set |=> $stable(state_out[c])
			&& $stable(state_out_inv[c]))
			else $error("Outputs moved while async set stayed low.");

		a_clear_holds:
		assert property (s_only_clear ##1 s_only_clear |=> $stable(state_out[c])
			&& $stable(state_out_inv[c]))
			else $error("Outputs moved while async clear stayed low.");

		a_release_repair:
		assert property (s_released |=> state_out[c] && !state_out_inv[c])
			else $error("Release from both low did not repair the complement.");

		// ----------------------------------------------------------------
		// Edge detection and complement tracking
		// ----------------------------------------------------------------
		// The detector forgets the clock level in reset, so a clock that drops
		// in the first cycle after release is not an edge; that cycle is skipped.
		a_fall_detect:
		assert property (!$past(rst)
			|-> fall[c] == ($past(cell_clk[c]) && !cell_clk[c]))
			else $error("Edge detector disagrees with the cell clock.");

		a_high_hold:
		assert property ((quiet && cell_clk[c]) ##1 (quiet && cell_clk[c])
			|=> $stable(state_out[c]))
			else $error("Output moved while the cell clock stood high.");

		a_inv_after_fall:
		assert property (quiet && fall[c] |=> state_out_inv[c] == !state_out[c])
			else $error("Complement did not follow the true output after an edge.");

		a_toggle_pair:
		assert property (s_fall_with(1'h1, 1'h1) ##0 $past(quiet)
			|=> state_out_inv[c] == !$past(state_out_inv[c]))
			else $error("Fall with both inputs high did not invert the complement.");
	end

endmodule

// ==== tb/djkff_board.sv ====
// Board-side model that makes the falling edges of each cell clock.
module djkff_board (
	// System
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Edge requests and cell clocks
	input  wire logic [1:0] fire,
	output logic      [1:0] cell_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cell clock drops on request
	// The clock rests high and drops for one cycle per request, so the
	// controls only ever move while the clock stands still.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cell_clk <= 2'h3;
		end else begin
			cell_clk <= ~fire;
		end
	end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the dual storage cell block.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk;
	logic       rst;
	logic [1:0] fire;
	logic [1:0] set_in;
	logic [1:0] rst_in;
	logic [1:0] aset_n;
	logic [1:0] aclr_n;
	logic [1:0] clk_c;
	logic [1:0] q;
	logic [1:0] qn;
	int         mismatches;
	int         n_tests;

	djkff_board i_board (.sys_clk(sys_clk), .rst(rst), .fire(fire), .cell_clk(clk_c));
	djkff_top i_dut (.sys_clk(sys_clk), .rst(rst), .cell_clk(clk_c), .set_input(set_in),
		.reset_input(rst_in), .async_set_n(aset_n), .async_clear_n(aclr_n),
		.state_out(q), .state_out_inv(qn));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [1:0] eq, input logic [1:0] eqn);
		n_tests++;
		if (q !== eq || qn !== eqn) begin
			mismatches++;
			$display("wrong value at %0t: got %h/%h expected %h/%h", $time, q, qn, eq, eqn);
		end
	endtask

	// One falling edge on cell c; returns once the answer is settled.
	task automatic edge_on(input int c, input logic s, input logic r);
		@(posedge sys_clk);
		set_in[c] <= s;
		rst_in[c] <= r;
		fire[c]   <= 1'b1;
		@(posedge sys_clk);
		fire[c] <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic ovr(input logic [1:0] s_n, input logic [1:0] c_n);
		@(posedge sys_clk);
		aset_n <= s_n;
		aclr_n <= c_n;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic t_sync;
		edge_on(0, 1'b1, 1'b0);
		chk(2'h1, 2'h2);
		edge_on(0, 1'b0, 1'b0);
		chk(2'h1, 2'h2);
		edge_on(0, 1'b1, 1'b1);
		chk(2'h0, 2'h3);
		edge_on(0, 1'b1, 1'b1);
		chk(2'h1, 2'h2);
		edge_on(1, 1'b1, 1'b1);
		chk(2'h3, 2'h0);
		edge_on(0, 1'b0, 1'b1);
		chk(2'h2, 2'h1);
	endtask

	task automatic t_steady;
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			set_in <= 2'(i);
			rst_in <= ~2'(i);
			repeat (2) @(posedge sys_clk);
			#1;
			chk(2'h2, 2'h1);
		end
	endtask

	task automatic t_async;
		ovr(2'h3, 2'h1);
		chk(2'h0, 2'h3);
		edge_on(1, 1'b1, 1'b0);
		chk(2'h0, 2'h3);
		ovr(2'h2, 2'h1);
		chk(2'h1, 2'h2);
		ovr(2'h2, 2'h0);
		chk(2'h1, 2'h3);
		ovr(2'h3, 2'h3);
		chk(2'h1, 2'h2);
		edge_on(0, 1'b0, 1'b1);
		chk(2'h0, 2'h3);
	endtask

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		mismatches = 0;
		n_tests    = 0;
		rst        = 1'b1;
		fire       = 2'h0;
		set_in     = 2'h0;
		rst_in     = 2'h0;
		aset_n     = 2'h3;
		aclr_n     = 2'h3;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(2'h0, 2'h3);
		t_sync();
		t_steady();
		t_async();
		finish_test();
	end
endmodule
